/* File: common/afm_map.svh */
// constants of the analog and absolute-encoder fault monitor: alarm codes,
// usage-setting values and cause bit positions; included by the monitor, its checker and the bench.
// Notes on behaviour
// - input one above threshold raises 39/0
// - input two above threshold raises 39/1
// - input three above threshold raises 39/2
// - zero threshold disables input one protection
// - supplies lost and capacitor low raise 40/0
// - 40 and 42 need encoder reset first
// - multi-turn count over raises 41/0
// - usage setting 2 ignores counter over
// - over-speed on battery alone raises 42/0
// - over-speed after encoder power loss raises 42
// - usage setting 1 suppresses absolute alarms
// - non-clearable alarms hold until power cycle
`ifndef AFM_MAP_SVH
`define AFM_MAP_SVH

`define AFM_MAIN_W 8
`define AFM_SUB_W 4
`define AFM_USAGE_W 2
`define AFM_CAUSE_W 6
`define AFM_PIN_W 7

`define AFM_MAIN_NONE 8'h00
`define AFM_MAIN_AIN_EXCESS 8'h27
`define AFM_MAIN_SYS_DOWN 8'h28
`define AFM_MAIN_CNT_OVER 8'h29
`define AFM_MAIN_OVERSPEED 8'h2A

`define AFM_SUB_0 4'h0
`define AFM_SUB_1 4'h1
`define AFM_SUB_2 4'h2

`define AFM_USAGE_INCREMENTAL 2'h1
`define AFM_USAGE_IGNORE_OVER 2'h2

// cause vector bit positions, also the order of fault_cause
`define AFM_BIT_AIN1 0
`define AFM_BIT_AIN2 1
`define AFM_BIT_AIN3 2
`define AFM_BIT_SYS_DOWN 3
`define AFM_BIT_CNT_OVER 4
`define AFM_BIT_OVERSPEED 5

// synchronised pin bundle positions
`define AFM_PIN_PWR_OK 0
`define AFM_PIN_BAT_OK 1
`define AFM_PIN_CAP_LOW 2
`define AFM_PIN_TURN_OVER 3
`define AFM_PIN_OVERSPEED 4
`define AFM_PIN_ABS_CLEARED 5
`define AFM_PIN_CLEAR 6

`endif

/* File: common/afm_pkg.sv */
// types of the fault monitor: alarm sources and supervisor states.
// assumes afm_map.svh is compiled alongside for the numeric constants.
package afm_pkg;

    typedef enum logic [2:0] {
        AFM_SRC_NONE,
        AFM_SRC_AIN1,
        AFM_SRC_AIN2,
        AFM_SRC_AIN3,
        AFM_SRC_SYS_DOWN,
        AFM_SRC_CNT_OVER,
        AFM_SRC_OVERSPEED
    } afm_src_t;

    typedef enum logic [1:0] {
        AFM_NORMAL,
        AFM_ALARM,
        AFM_HOLD_ENC,
        AFM_LOCKED
    } afm_state_t;

endpackage

/* File: src/afm_sync.sv */
// two-stage synchroniser for a bundle of asynchronous pin levels.
// assumes the levels are quasi-static; each bit is synchronised on its own.
`timescale 1ns/10ps
module afm_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // first stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    assign pin_sync = sync_reg;

endmodule

/* File: src/afm_threshold_cmp.sv */
// excess comparator for one analog channel, registered result.
// assumes level and threshold are unsigned words on mclk from the converter.
`timescale 1ns/10ps
module afm_threshold_cmp #(
    parameter int ADC_W = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADC_W-1:0] level,
    input wire logic [ADC_W-1:0] threshold,
    output logic excess
);

    logic excess_reg;
    logic excess_next;
    logic thr_enabled;

    // a zero threshold switches the protection off
    assign thr_enabled = (threshold != '0);
    assign excess_next = thr_enabled && (level > threshold);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            excess_reg <= 1'b0;
        end else begin
            excess_reg <= excess_next;
        end
    end

    assign excess = excess_reg;

endmodule

/* File: src/afm_fault_monitor.sv */
// fault monitor: analog excess, absolute-encoder supply, counter and speed
// alarms, with a latched main/sub code and clear handling.
// assumes encoder status pins are asynchronous and analog words are on mclk.
`timescale 1ns/10ps
`include "afm_map.svh"
module afm_fault_monitor #(
    parameter int ADC_W = 16,
    parameter int CONFIRM_CYCLES = 2
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADC_W-1:0] analog_input_one,
    input wire logic [ADC_W-1:0] analog_input_two,
    input wire logic [ADC_W-1:0] analog_input_three,
    input wire logic [ADC_W-1:0] ain1_excess_threshold,
    input wire logic [ADC_W-1:0] ain2_excess_threshold,
    input wire logic [ADC_W-1:0] ain3_excess_threshold,
    input wire logic [`AFM_USAGE_W-1:0] abs_encoder_usage_setting,
    input wire logic alarm_clear_input,
    input wire logic enc_main_power_ok,
    input wire logic enc_battery_ok,
    input wire logic enc_backup_cap_low,
    input wire logic enc_multiturn_over,
    input wire logic enc_overspeed,
    input wire logic enc_abs_cleared,
    output logic alarm_active,
    output logic [`AFM_MAIN_W-1:0] alarm_main_code,
    output logic [`AFM_SUB_W-1:0] alarm_sub_code,
    output logic alarm_nonclearable,
    output logic alarm_awaits_enc_reset,
    output logic clear_rejected,
    output logic [`AFM_CAUSE_W-1:0] fault_cause
);

    localparam int CNT_W = $clog2(CONFIRM_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(CONFIRM_CYCLES);

    // priority: the non-clearable counter over first, then supply loss,
    // speed, and the analog channels in order
    function automatic afm_pkg::afm_src_t pick_source(
        input logic [`AFM_CAUSE_W-1:0] det
    );
        afm_pkg::afm_src_t src;
        src = afm_pkg::AFM_SRC_NONE;
        if (det[`AFM_BIT_CNT_OVER]) begin
            src = afm_pkg::AFM_SRC_CNT_OVER;
        end else if (det[`AFM_BIT_SYS_DOWN]) begin
            src = afm_pkg::AFM_SRC_SYS_DOWN;
        end else if (det[`AFM_BIT_OVERSPEED]) begin
            src = afm_pkg::AFM_SRC_OVERSPEED;
        end else if (det[`AFM_BIT_AIN1]) begin
            src = afm_pkg::AFM_SRC_AIN1;
        end else if (det[`AFM_BIT_AIN2]) begin
            src = afm_pkg::AFM_SRC_AIN2;
        end else if (det[`AFM_BIT_AIN3]) begin
            src = afm_pkg::AFM_SRC_AIN3;
        end
        return src;
    endfunction

    function automatic logic [`AFM_MAIN_W-1:0] main_of(input afm_pkg::afm_src_t src);
        logic [`AFM_MAIN_W-1:0] code;
        code = `AFM_MAIN_NONE;
        unique case (src)
            afm_pkg::AFM_SRC_NONE: code = `AFM_MAIN_NONE;
            afm_pkg::AFM_SRC_AIN1: code = `AFM_MAIN_AIN_EXCESS;
            afm_pkg::AFM_SRC_AIN2: code = `AFM_MAIN_AIN_EXCESS;
            afm_pkg::AFM_SRC_AIN3: code = `AFM_MAIN_AIN_EXCESS;
            afm_pkg::AFM_SRC_SYS_DOWN: code = `AFM_MAIN_SYS_DOWN;
            afm_pkg::AFM_SRC_CNT_OVER: code = `AFM_MAIN_CNT_OVER;
            afm_pkg::AFM_SRC_OVERSPEED: code = `AFM_MAIN_OVERSPEED;
            default: code = `AFM_MAIN_NONE;
        endcase
        return code;
    endfunction

    function automatic logic [`AFM_SUB_W-1:0] sub_of(input afm_pkg::afm_src_t src);
        logic [`AFM_SUB_W-1:0] code;
        code = `AFM_SUB_0;
        if (src == afm_pkg::AFM_SRC_AIN2) begin
            code = `AFM_SUB_1;
        end else if (src == afm_pkg::AFM_SRC_AIN3) begin
            code = `AFM_SUB_2;
        end
        return code;
    endfunction

    // pin synchronisation
    logic [`AFM_PIN_W-1:0] pin_raw;
    logic [`AFM_PIN_W-1:0] pin_s;

    assign pin_raw[`AFM_PIN_PWR_OK] = enc_main_power_ok;
    assign pin_raw[`AFM_PIN_BAT_OK] = enc_battery_ok;
    assign pin_raw[`AFM_PIN_CAP_LOW] = enc_backup_cap_low;
    assign pin_raw[`AFM_PIN_TURN_OVER] = enc_multiturn_over;
    assign pin_raw[`AFM_PIN_OVERSPEED] = enc_overspeed;
    assign pin_raw[`AFM_PIN_ABS_CLEARED] = enc_abs_cleared;
    assign pin_raw[`AFM_PIN_CLEAR] = alarm_clear_input;

    afm_sync #(
        .W(`AFM_PIN_W)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_in(pin_raw),
        .pin_sync(pin_s)
    );

    // edges of the clear request and of the encoder-cleared report
    logic clear_d_reg;
    logic abs_cleared_d_reg;
    logic clear_edge;
    logic abs_cleared_edge;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clear_d_reg <= 1'b0;
            abs_cleared_d_reg <= 1'b0;
        end else begin
            clear_d_reg <= pin_s[`AFM_PIN_CLEAR];
            abs_cleared_d_reg <= pin_s[`AFM_PIN_ABS_CLEARED];
        end
    end

    assign clear_edge = pin_s[`AFM_PIN_CLEAR] && !clear_d_reg;
    assign abs_cleared_edge = pin_s[`AFM_PIN_ABS_CLEARED] && !abs_cleared_d_reg;

    // analog channels
    logic [ADC_W-1:0] lvl [3];
    logic [ADC_W-1:0] thr [3];
    logic [2:0] ain_excess;

    assign lvl[0] = analog_input_one;
    assign lvl[1] = analog_input_two;
    assign lvl[2] = analog_input_three;
    assign thr[0] = ain1_excess_threshold;
    assign thr[1] = ain2_excess_threshold;
    assign thr[2] = ain3_excess_threshold;

    generate
        for (genvar i = 0; i < 3; i++) begin : g_ain
            afm_threshold_cmp #(
                .ADC_W(ADC_W)
            ) u_cmp (
                .mclk(mclk),
                .rst_n(rst_n),
                .level(lvl[i]),
                .threshold(thr[i]),
                .excess(ain_excess[i])
            );
        end
    endgenerate

    // absolute-encoder conditions, gated by the usage setting
    logic abs_enabled;
    logic cnt_over_enabled;
    logic enc_power_lost;
    logic sys_down_raw;
    logic cnt_over_raw;
    logic overspeed_raw;
    logic [`AFM_CAUSE_W-1:0] raw_det;

    // incremental use means no absolute-encoder protection at all
    assign abs_enabled = (abs_encoder_usage_setting != `AFM_USAGE_INCREMENTAL);
    assign cnt_over_enabled = abs_enabled &&
        (abs_encoder_usage_setting != `AFM_USAGE_IGNORE_OVER);
    assign enc_power_lost = !pin_s[`AFM_PIN_PWR_OK];
    assign sys_down_raw = abs_enabled && enc_power_lost && !pin_s[`AFM_PIN_BAT_OK] &&
        pin_s[`AFM_PIN_CAP_LOW];
    // travel beyond the multi-turn range is the host's to avoid
    assign cnt_over_raw = cnt_over_enabled && pin_s[`AFM_PIN_TURN_OVER];
    // covers both battery-only outage and power lost while running
    assign overspeed_raw = abs_enabled && enc_power_lost &&
        pin_s[`AFM_PIN_OVERSPEED];

    assign raw_det[`AFM_BIT_AIN1] = ain_excess[0];
    assign raw_det[`AFM_BIT_AIN2] = ain_excess[1];
    assign raw_det[`AFM_BIT_AIN3] = ain_excess[2];
    assign raw_det[`AFM_BIT_SYS_DOWN] = sys_down_raw;
    assign raw_det[`AFM_BIT_CNT_OVER] = cnt_over_raw;
    assign raw_det[`AFM_BIT_OVERSPEED] = overspeed_raw;

    // persistence filter: a cause must hold for CONFIRM_CYCLES + 1 samples,
    // which trades a few cycles of latency for immunity to single glitches
    logic [`AFM_CAUSE_W-1:0] det;

    generate
        for (genvar b = 0; b < `AFM_CAUSE_W; b++) begin : g_filt
            logic [CNT_W-1:0] cnt_reg;
            logic [CNT_W-1:0] cnt_next;

            assign cnt_next = !raw_det[b] ? '0 :
                (cnt_reg == CNT_FULL) ? cnt_reg : cnt_reg + CNT_W'(1);
            assign det[b] = raw_det[b] && (cnt_reg == CNT_FULL);

            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    cnt_reg <= '0;
                end else begin
                    cnt_reg <= cnt_next;
                end
            end
        end
    endgenerate

    // alarm supervisor
    afm_pkg::afm_state_t state_reg;
    afm_pkg::afm_state_t state_next;
    afm_pkg::afm_src_t src_reg;
    afm_pkg::afm_src_t src_next;
    afm_pkg::afm_src_t new_src;
    logic [`AFM_MAIN_W-1:0] main_reg;
    logic [`AFM_MAIN_W-1:0] main_next;
    logic [`AFM_SUB_W-1:0] sub_reg;
    logic [`AFM_SUB_W-1:0] sub_next;
    logic reject_reg;
    logic reject_next;
    logic [`AFM_CAUSE_W-1:0] cause_reg;
    logic new_hit;
    logic new_locks;
    logic new_needs_enc;
    afm_pkg::afm_state_t latch_state;

    assign new_src = pick_source(det);
    assign new_hit = (new_src != afm_pkg::AFM_SRC_NONE);
    assign new_locks = (new_src == afm_pkg::AFM_SRC_CNT_OVER);
    assign new_needs_enc = (new_src == afm_pkg::AFM_SRC_SYS_DOWN) ||
        (new_src == afm_pkg::AFM_SRC_OVERSPEED);
    assign latch_state = new_locks ? afm_pkg::AFM_LOCKED :
        new_needs_enc ? afm_pkg::AFM_HOLD_ENC : afm_pkg::AFM_ALARM;

    always_comb begin
        state_next = state_reg;
        src_next = src_reg;
        main_next = main_reg;
        sub_next = sub_reg;
        reject_next = 1'b0;
        unique case (state_reg)
            afm_pkg::AFM_NORMAL: begin
                if (new_hit) begin
                    state_next = latch_state;
                    src_next = new_src;
                    main_next = main_of(new_src);
                    sub_next = sub_of(new_src);
                end
            end
            afm_pkg::AFM_ALARM: begin
                // later causes are not latched over the first one
                if (clear_edge) begin
                    // a cause still present re-latches: the set wins
                    state_next = new_hit ? latch_state : afm_pkg::AFM_NORMAL;
                    src_next = new_src;
                    main_next = main_of(new_src);
                    sub_next = sub_of(new_src);
                end
            end
            afm_pkg::AFM_HOLD_ENC: begin
                if (abs_cleared_edge) begin
                    state_next = afm_pkg::AFM_ALARM;
                end else if (clear_edge) begin
                    reject_next = 1'b1;
                end
            end
            afm_pkg::AFM_LOCKED: begin
                // only removing power leaves this state
                reject_next = clear_edge;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= afm_pkg::AFM_NORMAL;
            src_reg <= afm_pkg::AFM_SRC_NONE;
            main_reg <= `AFM_MAIN_NONE;
            sub_reg <= `AFM_SUB_0;
            reject_reg <= 1'b0;
            cause_reg <= '0;
        end else begin
            state_reg <= state_next;
            src_reg <= src_next;
            main_reg <= main_next;
            sub_reg <= sub_next;
            reject_reg <= reject_next;
            cause_reg <= det;
        end
    end

    assign alarm_active = (state_reg != afm_pkg::AFM_NORMAL);
    assign alarm_main_code = main_reg;
    assign alarm_sub_code = sub_reg;
    assign alarm_nonclearable = (state_reg == afm_pkg::AFM_LOCKED);
    assign alarm_awaits_enc_reset = (state_reg == afm_pkg::AFM_HOLD_ENC);
    assign clear_rejected = reject_reg;
    assign fault_cause = cause_reg;

endmodule

/* File: tb/afm_enc_model.sv */
// behavioural absolute encoder seen from the monitor's status pins.
// assumes the bench steers supplies, speed and turns at mclk edges.
`timescale 1ns/10ps
module afm_enc_model #(
    parameter int CAP_HOLD = 4
) (
    input wire logic mclk,
    input wire logic main_on,
    input wire logic bat_on,
    input wire logic fast,
    input wire logic reset_req,
    input wire logic [15:0] turns,
    output logic pwr_ok,
    output logic bat_ok,
    output logic cap_low,
    output logic turn_over,
    output logic overspeed,
    output logic abs_cleared
);
    int cap_cnt = 0;
    int clr_cnt = 0;
    // the backup capacitor only sags after both supplies have gone for a while
    always @(posedge mclk) begin
        cap_cnt <= (main_on || bat_on) ? 0 : ((cap_cnt < CAP_HOLD) ? cap_cnt + 1 : cap_cnt);
        clr_cnt <= reset_req ? 4 : ((clr_cnt > 0) ? clr_cnt - 1 : 0);
    end
    assign pwr_ok = main_on;
    assign bat_ok = bat_on;
    assign cap_low = cap_cnt >= CAP_HOLD;
    assign turn_over = turns > 16'h7FFF;
    assign overspeed = fast && !main_on;
    assign abs_cleared = clr_cnt != 0;
endmodule

/* File: tb/afm_fault_monitor_assertions.sv */
// assertions of the fault monitor: causes, latched codes and clear refusal.
// assumes it is bound to afm_fault_monitor; one clock, synchronous reset.
`timescale 1ns/10ps
`include "afm_map.svh"
module afm_fault_monitor_assertions #(
    parameter int ADC_W = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADC_W-1:0] analog_input_one,
    input wire logic [ADC_W-1:0] ain1_excess_threshold,
    input wire logic [`AFM_USAGE_W-1:0] abs_encoder_usage_setting,
    input wire logic alarm_clear_input,
    input wire logic enc_main_power_ok,
    input wire logic enc_battery_ok,
    input wire logic enc_backup_cap_low,
    input wire logic enc_overspeed,
    input wire logic alarm_active,
    input wire logic [`AFM_MAIN_W-1:0] alarm_main_code,
    input wire logic [`AFM_SUB_W-1:0] alarm_sub_code,
    input wire logic alarm_nonclearable,
    input wire logic alarm_awaits_enc_reset,
    input wire logic clear_rejected,
    input wire logic [`AFM_CAUSE_W-1:0] fault_cause
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire absolute = abs_encoder_usage_setting != `AFM_USAGE_INCREMENTAL;
    wire sys_down_pins = absolute && !enc_main_power_ok && !enc_battery_ok && enc_backup_cap_low;
    wire speed_pins = absolute && !enc_main_power_ok && enc_overspeed;
    // pipelines are at most five deep, so seven steady samples settle a cause
    sequence ain1_over;
        (analog_input_one > ain1_excess_threshold && ain1_excess_threshold != '0) [*7];
    endsequence
    sequence quiet_clear;
        (!alarm_clear_input) [*5];
    endsequence
    sequence usage_held(v);
        (abs_encoder_usage_setting == v) [*8];
    endsequence
    a_ain1_cause: assert property (ain1_over |-> fault_cause[`AFM_BIT_AIN1])
        else $error("input one excess not flagged");
    a_zero_thr: assert property ((ain1_excess_threshold == '0) [*7] |-> !fault_cause[`AFM_BIT_AIN1])
        else $error("disabled input one flagged");
    a_sys_down: assert property (sys_down_pins [*8] |-> fault_cause[`AFM_BIT_SYS_DOWN])
        else $error("system down not flagged");
    a_speed_cause: assert property (speed_pins [*8] |-> fault_cause[`AFM_BIT_OVERSPEED])
        else $error("over-speed not flagged");
    a_raise_code: assert property ($rose(alarm_active) |->
        (alarm_main_code == `AFM_MAIN_AIN_EXCESS) ? alarm_sub_code <= `AFM_SUB_2 :
        (alarm_main_code inside {[`AFM_MAIN_SYS_DOWN:`AFM_MAIN_OVERSPEED]} && alarm_sub_code == `AFM_SUB_0))
        else $error("raised alarm has a bad code");
    a_incr_mode: assert property (usage_held(`AFM_USAGE_INCREMENTAL) ##1 $rose(alarm_active)
        |-> alarm_main_code == `AFM_MAIN_AIN_EXCESS)
        else $error("absolute alarm in incremental mode");
    a_ignore_over: assert property (usage_held(`AFM_USAGE_IGNORE_OVER) ##1 $rose(alarm_active)
        |-> alarm_main_code != `AFM_MAIN_CNT_OVER)
        else $error("counter over raised while ignored");
    a_code_hold: assert property (quiet_clear ##0 (alarm_active && $past(alarm_active))
        |-> $stable(alarm_main_code) && $stable(alarm_sub_code))
        else $error("latched code changed without a clear");
    a_locked_hold: assert property (alarm_nonclearable |=>
        alarm_nonclearable && alarm_main_code == `AFM_MAIN_CNT_OVER)
        else $error("counter over alarm released");
    a_clear_refuse: assert property ($rose(clear_rejected) |->
        (alarm_nonclearable || alarm_awaits_enc_reset) ##1 !clear_rejected)
        else $error("clear refusal without cause or too long");
endmodule
bind afm_fault_monitor afm_fault_monitor_assertions #(.ADC_W(ADC_W)) u_afm_chk (
    .mclk(mclk), .rst_n(rst_n), .analog_input_one(analog_input_one),
    .ain1_excess_threshold(ain1_excess_threshold), .abs_encoder_usage_setting(abs_encoder_usage_setting),
    .alarm_clear_input(alarm_clear_input), .enc_main_power_ok(enc_main_power_ok),
    .enc_battery_ok(enc_battery_ok), .enc_backup_cap_low(enc_backup_cap_low), .enc_overspeed(enc_overspeed),
    .alarm_active(alarm_active), .alarm_main_code(alarm_main_code), .alarm_sub_code(alarm_sub_code),
    .alarm_nonclearable(alarm_nonclearable), .alarm_awaits_enc_reset(alarm_awaits_enc_reset),
    .clear_rejected(clear_rejected), .fault_cause(fault_cause)
);

/* File: tb/afm_fault_monitor_tb.sv */
// self-checking bench of the fault monitor with an encoder model on its pins.
// assumes design, package, header, model and checker are compiled first.
`timescale 1ns/10ps
`include "afm_map.svh"
module afm_fault_monitor_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] ain [3] = '{default: 16'h0000};
    logic [15:0] thr [3] = '{default: 16'h0000};
    logic [1:0] usage = 2'h0;
    logic clr = 1'b0;
    logic main_on = 1'b1;
    logic bat_on = 1'b1;
    logic fast = 1'b0;
    logic enc_rst = 1'b0;
    logic [15:0] turns = 16'h0000;
    logic pwr_ok, bat_ok, cap_low, turn_over, overspeed, abs_cleared;
    logic alarm_active, nonclr, awaits, clear_rejected, rej;
    logic [7:0] main_code;
    logic [3:0] sub_code;
    logic [5:0] cause;
    logic [11:0] code;
    logic [11:0] code_exp;
    logic [15:0] t;
    logic [15:0] lvl;
    int fails = 0;
    int num_checks = 0;
    int seed = 32'h881f;
    assign code = {main_code, sub_code};

    afm_enc_model u_enc (
        .mclk(mclk), .main_on(main_on), .bat_on(bat_on), .fast(fast), .reset_req(enc_rst), .turns(turns),
        .pwr_ok(pwr_ok), .bat_ok(bat_ok), .cap_low(cap_low), .turn_over(turn_over),
        .overspeed(overspeed), .abs_cleared(abs_cleared)
    );
    afm_fault_monitor uut (
        .mclk(mclk), .rst_n(rst_n),
        .analog_input_one(ain[0]), .analog_input_two(ain[1]), .analog_input_three(ain[2]),
        .ain1_excess_threshold(thr[0]), .ain2_excess_threshold(thr[1]), .ain3_excess_threshold(thr[2]),
        .abs_encoder_usage_setting(usage), .alarm_clear_input(clr),
        .enc_main_power_ok(pwr_ok), .enc_battery_ok(bat_ok), .enc_backup_cap_low(cap_low),
        .enc_multiturn_over(turn_over), .enc_overspeed(overspeed), .enc_abs_cleared(abs_cleared),
        .alarm_active(alarm_active), .alarm_main_code(main_code), .alarm_sub_code(sub_code),
        .alarm_nonclearable(nonclr), .alarm_awaits_enc_reset(awaits), .clear_rejected(clear_rejected),
        .fault_cause(cause)
    );

    initial begin
        forever #20 mclk = ~mclk;
    end

    function automatic logic [11:0] fault_code(input int src, input int u);
        if (u == 1 && src > 2) return 12'h000;
        if (u == 2 && src == 4) return 12'h000;
        case (src)
            0, 1, 2: return {`AFM_MAIN_AIN_EXCESS, 4'(src)};
            3: return {`AFM_MAIN_SYS_DOWN, `AFM_SUB_0};
            4: return {`AFM_MAIN_CNT_OVER, `AFM_SUB_0};
            default: return {`AFM_MAIN_OVERSPEED, `AFM_SUB_0};
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        tick(6);
        rst_n <= 1'b1;
        tick(1);
    endtask

    // the refusal is a one-cycle pulse, so it is watched on every edge
    task automatic pulse_clear();
        rej = 1'b0;
        clr <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            if (clear_rejected === 1'b1) rej = 1'b1;
            if (i == 3) clr <= 1'b0;
        end
    endtask

    task automatic complete_run();
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        check({alarm_active, nonclr, awaits, clear_rejected, cause, code}, 22'h000000);
        usage <= `AFM_USAGE_INCREMENTAL;
        // the quiet channels sit exactly on their threshold, which is no excess
        for (int ch = 0; ch < 3; ch++) begin
            t = (16'($random(seed)) & 16'h7FFF) | 16'h0001;
            lvl = t + 16'h0001 + (16'($random(seed)) & 16'h7FFF);
            for (int i = 0; i < 3; i++) begin
                thr[i] <= t;
                ain[i] <= (i == ch) ? lvl : t;
            end
            tick(8);
            check(code, fault_code(ch, 0));
            ain[(ch + 1) % 3] <= lvl;
            tick(8);
            check(code, fault_code(ch, 0));
            check(cause, 6'((1 << ch) | (1 << ((ch + 1) % 3))));
            ain[ch] <= t;
            ain[(ch + 1) % 3] <= t;
            tick(6);
            pulse_clear();
            check(alarm_active, 1'b0);
            check(rej, 1'b0);
        end
        thr[0] <= 16'h0000;
        ain[0] <= 16'hFFFF;
        tick(10);
        check(alarm_active, 1'b0);
        check(cause, 6'h00);
        // setting 3 is decoded as plain absolute use, so it is swept as well
        for (int u = 0; u < 4; u++) begin
            for (int k = 3; k < 6; k++) begin
                do_reset();
                usage <= 2'(u);
                main_on <= (k == 4);
                bat_on <= (k != 3);
                fast <= (k == 5);
                turns <= (k == 4) ? (16'h8000 | 16'($random(seed))) : (16'($random(seed)) & 16'h7FFF);
                code_exp = fault_code(k, u);
                tick(16);
                check(code, code_exp);
                check(nonclr, (k == 4) && code_exp != 12'h000);
                check(awaits, (k != 4) && code_exp != 12'h000);
                pulse_clear();
                check(rej, code_exp != 12'h000);
                check(code, code_exp);
                main_on <= 1'b1;
                bat_on <= 1'b1;
                fast <= 1'b0;
                turns <= 16'h0000;
                tick(8);
                enc_rst <= 1'b1;
                tick(1);
                enc_rst <= 1'b0;
                tick(8);
                pulse_clear();
                check(code, (k == 4) ? code_exp : 12'h000);
                check(nonclr, (k == 4) && code_exp != 12'h000);
                check(awaits, 1'b0);
            end
        end
        complete_run();
    end

    // the tests need under a thousand cycles; five thousand leaves ample margin
    initial begin
        tick(5000);
        fails++;
        complete_run();
    end
endmodule
